// ---- rtl/rcc_cfg.svh ----
// Timing counts and reset values for the reset and clock control block.
// Assumes inclusion by the package and the modules of this block only.
`ifndef RCC_CFG_SVH
`define RCC_CFG_SVH

// ****************************************************************
// Timing
// ****************************************************************
// Glitch width limit in picoseconds and the system clock period.
`define RCC_GLITCH_PS 3000
`define RCC_CLK_PERIOD_PS 5000
// Limit in whole cycles, rounded up, with a floor of one cycle.
`define RCC_GLITCH_RAW ((`RCC_GLITCH_PS + `RCC_CLK_PERIOD_PS - 1) / `RCC_CLK_PERIOD_PS)
`define RCC_GLITCH_CYC ((`RCC_GLITCH_RAW < 1) ? 1 : `RCC_GLITCH_RAW)
// Pulse stretch for a requested reset, in cycles.
`define RCC_RST_HOLD_CYC 8'h10
// Fast RC divider for the RTC slow clock option.
`define RCC_FRC_DIV 9'h100

// ****************************************************************
// Reset values
// ****************************************************************
`define RCC_CPU_SRC_RST 2'h0
`define RCC_CPU_DIV_RST 8'h02
`define RCC_SLOW_SRC_RST 2'h1
`define RCC_FAST_SRC_RST 1'h1

`endif

// ---- rtl/rcc_pkg.sv ----
// Types shared by the reset and clock control block.
// Assumes the timing header is on the include path.
package rcc_pkg;

    // CPU clock source codes.
    typedef enum logic [1:0] {
        RCC_CPU_XTAL = 2'h0,
        RCC_CPU_FRC = 2'h1,
        RCC_CPU_PLL = 2'h2
    } rcc_cpu_src_t;

    // RTC slow clock source codes.
    typedef enum logic [1:0] {
        RCC_SLOW_X32K = 2'h0,
        RCC_SLOW_SRC = 2'h1,
        RCC_SLOW_FRC256 = 2'h2
    } rcc_slow_src_t;

    // Reset request bundle, one bit per level.
    typedef struct packed {
        logic chip;
        logic system;
        logic core;
        logic cpu1;
        logic cpu0;
    } rcc_rst_req_t;

    // Reset outputs towards the rest of the chip.
    typedef struct packed {
        logic chip;
        logic rtc;
        logic digital;
        logic secure;
        logic cpu1;
        logic cpu0;
    } rcc_rst_out_t;

    // Reset stretch state.
    typedef enum logic [0:0] {
        RCC_ST_IDLE = 1'b0,
        RCC_ST_HOLD = 1'b1
    } rcc_hold_st_t;

endpackage : rcc_pkg

// ---- rtl/rcc_glitch_det.sv ----
// Glitch detector for the sampled main crystal clock.
// Assumes the crystal level is sampled as a synchronous input.
`timescale 1ns/1ps
`include "rcc_cfg.svh"

module rcc_glitch_det
    import rcc_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Sampled crystal level.
    input wire logic xtal_i,
    // Block flag, sticky until reset.
    output logic block_o
);

    // ****************************************************************
    // Pulse width measurement
    // ****************************************************************
    logic prev_q;
    logic prev_d;
    logic [7:0] width_q;
    logic [7:0] width_d;
    logic block_q;
    logic block_d;

    // A level seen on no more samples than the limit may be narrower than it: a glitch.
    always_comb begin
        prev_d = xtal_i;
        block_d = block_q;
        width_d = width_q;
        if (xtal_i != prev_q) begin
            if ((width_q != 8'h00) && (width_q <= 8'(`RCC_GLITCH_CYC))) begin
                block_d = 1'b1;
            end
            width_d = 8'h01;
        end else if (width_q != 8'hFF) begin
            width_d = width_q + 8'h01;
        end
    end

    // Registers for the measurement.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_q <= 1'b0;
            width_q <= 8'h00;
            block_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            width_q <= width_d;
            block_q <= block_d;
        end
    end

    assign block_o = block_q;

endmodule // rcc_glitch_det

// ---- rtl/rcc_top.sv ----
// Reset and clock control: nested reset levels and clock selection.
// Assumes clock sources arrive as sampled levels on the system clock.
`timescale 1ns/1ps
`include "rcc_cfg.svh"

module rcc_top
    import rcc_pkg::*;
(
    // Clock and reset.
    input wire logic CLK_SYS_I,
    input wire logic SYS_RST_I,
    // Software reset requests from the cores.
    input wire logic CPU0_SW_CPU_RST_I,
    input wire logic CPU1_SW_CPU_RST_I,
    input wire logic SW_CORE_RST_I,
    input wire logic SW_SYSTEM_RST_I,
    // Hardware reset requests.
    input wire logic HW_CPU0_RST_I,
    input wire logic HW_CPU1_RST_I,
    input wire logic HW_CORE_RST_I,
    input wire logic HW_SYSTEM_RST_I,
    input wire logic HW_CHIP_RST_I,
    // Clock configuration written by a core.
    input wire logic CLK_CFG_WR_I,
    input wire logic [1:0] CPU_CLK_SRC_I,
    input wire logic [7:0] CPU_CLK_DIV_I,
    input wire logic [1:0] RTC_SLOW_SRC_I,
    input wire logic RTC_FAST_SRC_I,
    // Sampled clock source levels.
    input wire logic MAIN_CRYSTAL_CLOCK_I,
    input wire logic FAST_RC_CLK_I,
    input wire logic PLL_CLK_I,
    input wire logic X32K_CLK_I,
    input wire logic SLOW_RC_CLK_I,
    // Reset outputs.
    output rcc_rst_out_t RST_O,
    output logic CPU0_VECTOR_FETCH_O,
    output logic CPU1_VECTOR_FETCH_O,
    // Clock outputs and status.
    output logic CPU_CLK_O,
    output logic RTC_SLOW_CLK_O,
    output logic RTC_FAST_CLK_O,
    output logic XTAL_BLOCKED_O
);

    // ****************************************************************
    // Reset requests
    // ****************************************************************
    rcc_rst_req_t req;
    rcc_rst_req_t lvl;
    logic xtal_blocked;
    logic xtal_ok;

    // Software and hardware sources merge per level.
    always_comb begin
        req.cpu0 = CPU0_SW_CPU_RST_I | HW_CPU0_RST_I;
        req.cpu1 = CPU1_SW_CPU_RST_I | HW_CPU1_RST_I;
        req.core = SW_CORE_RST_I | HW_CORE_RST_I;
        req.system = SW_SYSTEM_RST_I | HW_SYSTEM_RST_I;
        req.chip = HW_CHIP_RST_I | SYS_RST_I;
    end

    // Wider levels pull in every narrower level.
    always_comb begin
        lvl.chip = req.chip;
        lvl.system = lvl.chip | req.system;
        lvl.core = lvl.system | req.core;
        lvl.cpu0 = lvl.core | req.cpu0;
        lvl.cpu1 = lvl.core | req.cpu1;
    end

    // ****************************************************************
    // Reset stretching, one counter per level
    // ****************************************************************
    logic [4:0] hold_act;
    logic [4:0] hold_done;

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_hold
            rcc_hold_st_t st_q;
            rcc_hold_st_t st_d;
            logic [7:0] cnt_q;
            logic [7:0] cnt_d;
            logic done_q;
            logic done_d;

            // Hold each level for a fixed time after its request drops.
            always_comb begin
                st_d = st_q;
                cnt_d = cnt_q;
                done_d = 1'b0;
                case (st_q)
                    RCC_ST_IDLE: begin
                        if (lvl[gi]) begin
                            st_d = RCC_ST_HOLD;
                            cnt_d = `RCC_RST_HOLD_CYC;
                        end
                    end
                    RCC_ST_HOLD: begin
                        if (lvl[gi]) begin
                            cnt_d = `RCC_RST_HOLD_CYC;
                        end else if (cnt_q == 8'h00) begin
                            st_d = RCC_ST_IDLE;
                            done_d = 1'b1;
                        end else begin
                            cnt_d = cnt_q - 8'h01;
                        end
                    end
                    default: begin
                        st_d = RCC_ST_IDLE;
                    end
                endcase
            end

            // Start in hold so every domain leaves reset cleanly.
            always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
                if (SYS_RST_I) begin
                    st_q <= RCC_ST_HOLD;
                    cnt_q <= `RCC_RST_HOLD_CYC;
                    done_q <= 1'b0;
                end else begin
                    st_q <= st_d;
                    cnt_q <= cnt_d;
                    done_q <= done_d;
                end
            end

            assign hold_act[gi] = (st_q == RCC_ST_HOLD);
            assign hold_done[gi] = done_q;
        end
    endgenerate

    // Map stretched levels onto the reset outputs.
    always_comb begin
        RST_O.cpu0 = hold_act[0];
        RST_O.cpu1 = hold_act[1];
        RST_O.secure = hold_act[0];
        RST_O.digital = hold_act[2];
        RST_O.rtc = hold_act[3];
        RST_O.chip = hold_act[4];
        CPU0_VECTOR_FETCH_O = hold_done[0];
        CPU1_VECTOR_FETCH_O = hold_done[1];
    end

    // ****************************************************************
    // Clock configuration
    // ****************************************************************
    logic [1:0] cpu_src_q;
    logic [1:0] cpu_src_d;
    logic [7:0] cpu_div_q;
    logic [7:0] cpu_div_d;
    logic [1:0] slow_src_q;
    logic [1:0] slow_src_d;
    logic fast_src_q;
    logic fast_src_d;

    // CPU clock settings fall back to defaults on a CPU0 reset, RTC clock settings on a system reset.
    always_comb begin
        cpu_src_d = cpu_src_q;
        cpu_div_d = cpu_div_q;
        slow_src_d = slow_src_q;
        fast_src_d = fast_src_q;
        if (hold_act[0]) begin
            cpu_src_d = `RCC_CPU_SRC_RST;
            cpu_div_d = `RCC_CPU_DIV_RST;
        end else if (CLK_CFG_WR_I) begin
            cpu_src_d = CPU_CLK_SRC_I;
            cpu_div_d = CPU_CLK_DIV_I;
        end
        if (hold_act[3]) begin
            slow_src_d = `RCC_SLOW_SRC_RST;
            fast_src_d = `RCC_FAST_SRC_RST;
        end else if (CLK_CFG_WR_I) begin
            slow_src_d = RTC_SLOW_SRC_I;
            fast_src_d = RTC_FAST_SRC_I;
        end
    end

    // Configuration registers.
    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cpu_src_q <= `RCC_CPU_SRC_RST;
            cpu_div_q <= `RCC_CPU_DIV_RST;
            slow_src_q <= `RCC_SLOW_SRC_RST;
            fast_src_q <= `RCC_FAST_SRC_RST;
        end else begin
            cpu_src_q <= cpu_src_d;
            cpu_div_q <= cpu_div_d;
            slow_src_q <= slow_src_d;
            fast_src_q <= fast_src_d;
        end
    end

    // ****************************************************************
    // Crystal glitch guard
    // ****************************************************************
    rcc_glitch_det u_glitch (
        .clk_i(CLK_SYS_I),
        .rst_i(SYS_RST_I),
        .xtal_i(MAIN_CRYSTAL_CLOCK_I),
        .block_o(xtal_blocked)
    );

    assign xtal_ok = MAIN_CRYSTAL_CLOCK_I & ~xtal_blocked;

    // ****************************************************************
    // Clock dividers and selection
    // ****************************************************************
    logic src_prev_q;
    logic src_prev_d;
    logic xtal_prev_q;
    logic xtal_prev_d;
    logic frc_prev_q;
    logic frc_prev_d;
    logic [7:0] cpu_cnt_q;
    logic [7:0] cpu_cnt_d;
    logic cpu_clk_q;
    logic cpu_clk_d;
    logic xtal2_q;
    logic xtal2_d;
    logic [8:0] frc_cnt_q;
    logic [8:0] frc_cnt_d;
    logic frc256_q;
    logic frc256_d;
    logic slow_q;
    logic slow_d;
    logic fast_q;
    logic fast_d;
    logic cpu_src_lvl;

    // Level of the chosen CPU source.
    always_comb begin
        case (cpu_src_q)
            RCC_CPU_XTAL: cpu_src_lvl = xtal_ok;
            RCC_CPU_FRC: cpu_src_lvl = FAST_RC_CLK_I;
            RCC_CPU_PLL: cpu_src_lvl = PLL_CLK_I;
            default: cpu_src_lvl = xtal_ok;
        endcase
    end

    // Edge-counting dividers that toggle outputs on rising source edges; a CPU divide of 0 or 1 passes the source level.
    always_comb begin
        src_prev_d = cpu_src_lvl;
        xtal_prev_d = xtal_ok;
        frc_prev_d = FAST_RC_CLK_I;
        cpu_cnt_d = cpu_cnt_q;
        cpu_clk_d = cpu_clk_q;
        xtal2_d = xtal2_q;
        frc_cnt_d = frc_cnt_q;
        frc256_d = frc256_q;
        if (cpu_src_lvl && !src_prev_q) begin
            if (cpu_div_q <= 8'h01) begin
                cpu_clk_d = 1'b1;
            end else if (cpu_cnt_q + 8'h01 >= (cpu_div_q >> 1)) begin
                cpu_cnt_d = 8'h00;
                cpu_clk_d = ~cpu_clk_q;
            end else begin
                cpu_cnt_d = cpu_cnt_q + 8'h01;
            end
        end else if (!cpu_src_lvl && src_prev_q && (cpu_div_q <= 8'h01)) begin
            cpu_clk_d = 1'b0;
        end
        if (xtal_ok && !xtal_prev_q) begin
            xtal2_d = ~xtal2_q;
        end
        if (FAST_RC_CLK_I && !frc_prev_q) begin
            if (frc_cnt_q == (`RCC_FRC_DIV >> 1) - 9'h001) begin
                frc_cnt_d = 9'h000;
                frc256_d = ~frc256_q;
            end else begin
                frc_cnt_d = frc_cnt_q + 9'h001;
            end
        end
    end

    // Output clock selection for the RTC domain.
    always_comb begin
        case (slow_src_q)
            RCC_SLOW_X32K: slow_d = X32K_CLK_I;
            RCC_SLOW_SRC: slow_d = SLOW_RC_CLK_I;
            RCC_SLOW_FRC256: slow_d = frc256_q;
            default: slow_d = SLOW_RC_CLK_I;
        endcase
        fast_d = fast_src_q ? FAST_RC_CLK_I : xtal2_q;
    end

    // Divider and output registers.
    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            src_prev_q <= 1'b0;
            xtal_prev_q <= 1'b0;
            frc_prev_q <= 1'b0;
            cpu_cnt_q <= 8'h00;
            cpu_clk_q <= 1'b0;
            xtal2_q <= 1'b0;
            frc_cnt_q <= 9'h000;
            frc256_q <= 1'b0;
            slow_q <= 1'b0;
            fast_q <= 1'b0;
        end else begin
            src_prev_q <= src_prev_d;
            xtal_prev_q <= xtal_prev_d;
            frc_prev_q <= frc_prev_d;
            cpu_cnt_q <= cpu_cnt_d;
            cpu_clk_q <= cpu_clk_d;
            xtal2_q <= xtal2_d;
            frc_cnt_q <= frc_cnt_d;
            frc256_q <= frc256_d;
            slow_q <= slow_d;
            fast_q <= fast_d;
        end
    end

    // The slow clock feeds the RTC counter, watchdog and low-power logic.
    assign CPU_CLK_O = cpu_clk_q;
    assign RTC_SLOW_CLK_O = slow_q;
    assign RTC_FAST_CLK_O = fast_q;
    assign XTAL_BLOCKED_O = xtal_blocked;

endmodule // rcc_top

// ---- sim/rcc_top_sva.sv ----
// Checker on the ports of the reset and clock control top.
// Assumes it is bound to rcc_top and clocked by the system clock.
`timescale 1ns/1ps

module rcc_top_sva
    import rcc_pkg::*;
(
    // Clock and reset.
    input wire logic CLK_SYS_I,
    input wire logic SYS_RST_I,
    // Reset requests.
    input wire logic CPU0_SW_CPU_RST_I,
    input wire logic CPU1_SW_CPU_RST_I,
    input wire logic SW_CORE_RST_I,
    input wire logic SW_SYSTEM_RST_I,
    input wire logic HW_CPU0_RST_I,
    input wire logic HW_CPU1_RST_I,
    input wire logic HW_CORE_RST_I,
    input wire logic HW_SYSTEM_RST_I,
    input wire logic HW_CHIP_RST_I,
    // Outputs under watch.
    input wire rcc_rst_out_t RST_O,
    input wire logic CPU0_VECTOR_FETCH_O,
    input wire logic CPU1_VECTOR_FETCH_O,
    input wire logic XTAL_BLOCKED_O
);
    // ********************
    // Helper logic
    // ********************
    // Requests folded per level; anything that reaches core one.
    logic c0_req, c1_req, core_req, sys_req, wide1;
    logic [4:0] cnt_d, cnt_q;
    assign c0_req = CPU0_SW_CPU_RST_I | HW_CPU0_RST_I;
    assign c1_req = CPU1_SW_CPU_RST_I | HW_CPU1_RST_I;
    assign core_req = SW_CORE_RST_I | HW_CORE_RST_I;
    assign sys_req = SW_SYSTEM_RST_I | HW_SYSTEM_RST_I;
    assign wide1 = c1_req | core_req | sys_req | HW_CHIP_RST_I;

    // Counts edges since core one was last requested, saturating.
    always_comb begin
        cnt_d = wide1 ? 5'h00 : (cnt_q == 5'h1F ? cnt_q : cnt_q + 5'h01);
    end

    // Registers the count.
    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) cnt_q <= 5'h00;
        else cnt_q <= cnt_d;
    end

    // ********************
    // Assertions
    // ********************
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (SYS_RST_I);

    // A boot is a fetch pulse lasting one cycle.
    sequence boot0_s;
        CPU0_VECTOR_FETCH_O ##1 !CPU0_VECTOR_FETCH_O;
    endsequence
    sequence boot1_s;
        CPU1_VECTOR_FETCH_O ##1 !CPU1_VECTOR_FETCH_O;
    endsequence

    cpu0_scope_a: assert property (c0_req |=> RST_O.cpu0 && RST_O.secure)
        else $error("cpu0 reset scope wrong");
    cpu1_scope_a: assert property (c1_req |=> RST_O.cpu1)
        else $error("cpu1 reset missing");
    core_scope_a: assert property (core_req |=>
        RST_O.digital && RST_O.secure && RST_O.cpu0 && RST_O.cpu1)
        else $error("core reset scope wrong");
    system_scope_a: assert property (sys_req |=>
        RST_O.rtc && RST_O.digital && RST_O.secure && RST_O.cpu0 && RST_O.cpu1)
        else $error("system reset scope wrong");
    chip_scope_a: assert property (HW_CHIP_RST_I |=> RST_O == 6'h3F)
        else $error("chip reset scope wrong");
    reset_hold_a: assert property (cnt_q < 5'h0E |-> RST_O.cpu1)
        else $error("cpu1 reset released early");
    release_time_a: assert property ($fell(RST_O.cpu1) |-> cnt_q inside {[5'h0E:5'h13]})
        else $error("cpu1 reset released late");
    boot0_start_a: assert property ($fell(RST_O.cpu0) |-> boot0_s)
        else $error("cpu0 boot pulse wrong");
    boot1_start_a: assert property ($fell(RST_O.cpu1) |-> boot1_s)
        else $error("cpu1 boot pulse wrong");
    block_sticky_a: assert property (XTAL_BLOCKED_O |=> XTAL_BLOCKED_O)
        else $error("crystal block flag dropped");
endmodule // rcc_top_sva

bind rcc_top rcc_top_sva sva_u (.CLK_SYS_I, .SYS_RST_I, .CPU0_SW_CPU_RST_I, .CPU1_SW_CPU_RST_I,
    .SW_CORE_RST_I, .SW_SYSTEM_RST_I, .HW_CPU0_RST_I, .HW_CPU1_RST_I, .HW_CORE_RST_I,
    .HW_SYSTEM_RST_I, .HW_CHIP_RST_I, .RST_O, .CPU0_VECTOR_FETCH_O, .CPU1_VECTOR_FETCH_O,
    .XTAL_BLOCKED_O);

// ---- sim/rcc_core_model.sv ----
// Model of the two cores on the far side, counting reset-vector boots.
// Assumes resets and fetch pulses are registered on the system clock.
`timescale 1ns/1ps

module rcc_core_model
    import rcc_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Resets and fetch pulses from the block.
    input wire rcc_rst_out_t rst_out_i,
    input wire logic fetch0_i,
    input wire logic fetch1_i,
    // Boot counts.
    output logic [7:0] boot0_o,
    output logic [7:0] boot1_o
);
    // A core boots only on a fetch pulse with its own reset released.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            boot0_o <= 8'h00;
            boot1_o <= 8'h00;
        end else begin
            if (fetch0_i && !rst_out_i.cpu0) boot0_o <= boot0_o + 8'h01;
            if (fetch1_i && !rst_out_i.cpu1) boot1_o <= boot1_o + 8'h01;
        end
    end
endmodule // rcc_core_model

// ---- sim/reset_and_clock_control_test.sv ----
// Self-checking bench for the reset and clock control top.
// Assumes the package, header, checker and core model are compiled first.
`timescale 1ns/1ps

module reset_and_clock_control_test;
    import rcc_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [8:0] req = 9'h000;
    logic cfg_wr = 1'b0;
    logic [1:0] cpu_src = 2'h0;
    logic [7:0] cpu_div = 8'h02;
    logic [1:0] slow_src = 2'h1;
    logic fast_src = 1'b1;
    logic xtal = 1'b0, frc = 1'b0, pll = 1'b0, x32k = 1'b0, src = 1'b0;
    logic xtal_run = 1'b0, frc_run = 1'b0, ph = 1'b0;
    logic f0, f1, cpu_clk, slow_clk, fast_clk, blocked;
    rcc_rst_out_t rst_o;
    rcc_rst_out_t prev = 6'h3F;
    logic [7:0] boot0, boot1, boot0_exp, boot1_exp;
    logic [5:0] exp_q[$];
    int errors = 0;
    int tests_run = 0;
    int nc, nf, ns;

    // Clock at 200 MHz.
    always #2.5 clk = ~clk;

    rcc_top dut_u (
        .CLK_SYS_I(clk), .SYS_RST_I(rst),
        .CPU0_SW_CPU_RST_I(req[0]), .HW_CPU0_RST_I(req[1]),
        .CPU1_SW_CPU_RST_I(req[2]), .HW_CPU1_RST_I(req[3]),
        .SW_CORE_RST_I(req[4]), .HW_CORE_RST_I(req[5]),
        .SW_SYSTEM_RST_I(req[6]), .HW_SYSTEM_RST_I(req[7]), .HW_CHIP_RST_I(req[8]),
        .CLK_CFG_WR_I(cfg_wr), .CPU_CLK_SRC_I(cpu_src), .CPU_CLK_DIV_I(cpu_div),
        .RTC_SLOW_SRC_I(slow_src), .RTC_FAST_SRC_I(fast_src),
        .MAIN_CRYSTAL_CLOCK_I(xtal), .FAST_RC_CLK_I(frc), .PLL_CLK_I(pll),
        .X32K_CLK_I(x32k), .SLOW_RC_CLK_I(src),
        .RST_O(rst_o), .CPU0_VECTOR_FETCH_O(f0), .CPU1_VECTOR_FETCH_O(f1),
        .CPU_CLK_O(cpu_clk), .RTC_SLOW_CLK_O(slow_clk), .RTC_FAST_CLK_O(fast_clk),
        .XTAL_BLOCKED_O(blocked)
    );

    rcc_core_model core_u (.clk_i(clk), .rst_i(rst), .rst_out_i(rst_o),
        .fetch0_i(f0), .fetch1_i(f1), .boot0_o(boot0), .boot1_o(boot1));

    // ********************
    // Helpers
    // ********************
    // Crystal toggles every two cycles and fast RC every cycle when enabled.
    always @(negedge clk) begin
        ph <= ~ph;
        if (xtal_run && ph) xtal <= ~xtal;
        if (frc_run) frc <= ~frc;
    end

    // Compares each fresh reset pattern with the oldest note.
    always @(negedge clk) begin
        if (prev === 6'h00 && rst_o !== 6'h00) begin
            check({2'h0, rst_o},
                {2'h0, exp_q.size() ? exp_q.pop_front() : 6'h00});
        end
        prev = rst_o;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic near(input int got, input int want);
        check({7'h0, got >= want - 1 && got <= want + 1}, 8'h01);
    endtask

    task automatic wrap_up();
        if (errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Pattern of reset outputs that a request set raises from idle.
    function automatic logic [5:0] exp_of(input logic [8:0] r);
        logic [5:0] e;
        e = 6'h00;
        if (|r[1:0]) e = e | 6'h05;
        if (|r[3:2]) e = e | 6'h02;
        if (|r[5:4]) e = e | 6'h0F;
        if (|r[7:6]) e = e | 6'h1F;
        if (r[8]) e = e | 6'h3F;
        return e;
    endfunction

    // Pulses a request set, waits for release and checks boots.
    task automatic do_req(input logic [8:0] r);
        logic [5:0] e;
        e = exp_of(r);
        @(negedge clk);
        req = r;
        if (e != 6'h00) exp_q.push_back(e);
        boot0_exp += e[0];
        boot1_exp += e[1];
        repeat (2) @(negedge clk);
        req = 9'h000;
        for (int i = 0; i < 40 && rst_o !== 6'h00; i++) @(negedge clk);
        repeat (3) @(negedge clk);
        check(boot0, boot0_exp);
        check(boot1, boot1_exp);
    endtask

    task automatic cfg(input logic [1:0] cs, input logic [1:0] ss, input logic fs);
        @(negedge clk);
        cpu_src = cs;
        cpu_div = 8'h01;
        slow_src = ss;
        fast_src = fs;
        cfg_wr = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask

    // Counts level changes of the three clock outputs over n cycles.
    task automatic count(input int n);
        logic a, b, d;
        nc = 0;
        nf = 0;
        ns = 0;
        repeat (n) begin
            a = cpu_clk;
            b = fast_clk;
            d = slow_clk;
            @(negedge clk);
            nc += int'(cpu_clk !== a);
            nf += int'(fast_clk !== b);
            ns += int'(slow_clk !== d);
        end
    endtask

    // ********************
    // Tests
    // ********************
    initial begin
        void'($urandom(32'hBB75FCCF));
        boot0_exp = 8'h01;
        boot1_exp = 8'h01;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (25) @(negedge clk);
        for (int i = 0; i < 9; i++) do_req(9'h001 << i);
        for (int i = 0; i < 6; i++) do_req(9'($urandom));
        // Divided and undivided crystal paths, then fast RC over 256.
        xtal_run = 1'b1;
        count(64);
        near(nc, 16);
        cfg(2'h0, 2'h2, 1'b0);
        count(64);
        near(nc, 32);
        near(nf, 16);
        xtal_run = 1'b0;
        frc_run = 1'b1;
        count(1024);
        near(ns, 4);
        frc_run = 1'b0;
        // Steady random levels routed through each selector.
        for (int k = 0; k < 6; k++) begin
            @(negedge clk);
            {xtal, frc, pll, x32k, src} = 5'($urandom);
            cfg(2'(k % 3), 2'(k % 2), 1'b1);
            repeat (8) @(negedge clk);
            check({7'h0, cpu_clk}, {7'h0, k % 3 == 0 ? xtal : k % 3 == 1 ? frc : pll});
            check({7'h0, slow_clk}, {7'h0, k % 2 ? src : x32k});
            check({7'h0, fast_clk}, {7'h0, frc});
        end
        // A one-cycle crystal level latches the block and silences it.
        check({7'h0, blocked}, 8'h00);
        xtal = ~xtal;
        @(negedge clk);
        xtal = ~xtal;
        repeat (4) @(negedge clk);
        check({7'h0, blocked}, 8'h01);
        cfg(2'h0, 2'h1, 1'b1);
        xtal = 1'b1;
        repeat (8) @(negedge clk);
        check({7'h0, cpu_clk}, 8'h00);
        // A mid-run system reset acts as chip reset and clears the block.
        exp_q.push_back(6'h3F);
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        check({7'h0, blocked}, 8'h00);
        wrap_up();
    end

    // Watchdog against a hang.
    initial begin
        #50000;
        errors++;
        wrap_up();
    end
endmodule // reset_and_clock_control_test
